// >>> hdl/sclog_pkg.sv
// Shared constants and types of the serial capture logger
package sclog_pkg;
  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CONN_FLUSH_S = 5;
  localparam int FAST_FLUSH_S = 1;
  localparam int ESC_GUARD_S = 1;
  localparam int ESC_WINDOW_S = 1;
  localparam int ESC_WAIT_S = 2;
  localparam int STAMP_MS = 1;
  localparam int CONN_FLUSH_CYC = CONN_FLUSH_S * CLK_HZ;
  localparam int FAST_FLUSH_CYC = FAST_FLUSH_S * CLK_HZ;
  localparam int ESC_GUARD_CYC = ESC_GUARD_S * CLK_HZ;
  localparam int ESC_WINDOW_CYC = ESC_WINDOW_S * CLK_HZ;
  localparam int ESC_WAIT_CYC = ESC_WAIT_S * CLK_HZ;
  localparam int STAMP_CYC = STAMP_MS * (CLK_HZ / 1000);
  localparam int FIFO_DEPTH_DEF = 16;
  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_LIMIT = 6'h08;
  localparam logic [5:0] ADDR_ESCCHAR = 6'h0c;
  localparam logic [5:0] ADDR_RATE = 6'h10;
  localparam logic [5:0] ADDR_FILEBYTES = 6'h14;
  localparam logic [31:0] LIMIT_RST = 32'hee6b2800;
  localparam logic [31:0] RATE_RST = 32'h00004b00;
  localparam logic [31:0] HS_RATE_BPS = 32'h000f4240;
  localparam logic [7:0] ESC_RS232_RST = 8'h2d;
  localparam logic [7:0] ESC_LOGIC_RST = 8'h26;
  // CTRL fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LOGEN = 2;
  localparam int CTRL_MARKUP = 3;
  localparam int CTRL_TRIGSTOP = 4;
  localparam int CTRL_CMDDIS_LSB = 5;
  localparam int CTRL_PORTSEL = 7;
  // STATUS fields
  localparam int STAT_CARD = 0;
  localparam int STAT_ESCAPED = 1;
  localparam int STAT_HS = 2;
  localparam int STAT_OVF = 3;
  localparam int STAT_MODE_LSB = 4;
  // LED positions (LED n sits at bit n-1)
  localparam int LED_FAST = 1;
  localparam int LED_CONN_OFF_A = 6;
  localparam int LED_RS232 = 7;
  localparam int LED_LOGIC = 8;
  localparam int LED_CONN_OFF_B = 9;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_CMD, MODE_CONNECT, MODE_PLAIN, MODE_FAST} sclog_mode_type;
  typedef enum logic [1:0] {ESC_IDLE, ESC_ARMED, ESC_COUNT, ESC_WAIT} sclog_esc_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sclog_byte_type;
  typedef struct packed {
    logic chan;
    logic [26:0] stampMs;
    logic [7:0] data;
  } sclog_rec_type;
endpackage

// >>> hdl/sclog_fifo.sv
// Record buffer between the receive ports and the card writer
`timescale 1ns/1ns
module sclog_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input logic clk_sys,
  input logic rstn,
  input logic inValid,
  input logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input logic outReady
);
  import sclog_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sclog_fifo_type;
  sclog_fifo_type st_r, st_nxt;
  logic full, empty, push, pop;

  assign full = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
  assign empty = st_r.wp == st_r.rp;
  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = st_r.mem[st_r.rp[AW-1:0]];
  assign push = inValid & ~full;
  assign pop = outReady & ~empty;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp[AW-1:0]] = inData;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_keep;
    push && !pop |=> (st_r.wp - st_r.rp) == ($past(st_r.wp) - $past(st_r.rp) + 1'b1);
  endproperty
  a_keep: assert property (p_keep) else $error("accepted record not held");
endmodule // sclog_fifo

// >>> hdl/sclog_top.sv
// Serial capture logger: forwarding, escape detect, logging to card
// Function
// - Connect mode forwards bytes between both ports
// - Connect logging records every byte with stamp
// - Connect logging flushes card every five seconds
// - Connect configuration survives card removal
// - Plain logging stores selected port, flush five seconds
// - Card reinsertion starts a new log file
// - Fast capture stores one channel until stopped
// - Trigger variant stops fast capture on trigger
// - Fast start cancels connect; removal ends capture
// - Fast capture appends, never truncates files
// - Fast capture flushes at least once per second
// - Fast capture toggles second LED on writes
// - Above 1Mbps freeze LEDs, store only
// - High-speed ends on removal or trigger
// - File at size limit rolls to new file
// - Per-port command interpretation can be disabled
// - Default escape chars minus and ampersand
// - Connect LEDs eight and nine show receive
`timescale 1ns/1ns
module sclog_top #(
  parameter int FIFO_DEPTH = sclog_pkg::FIFO_DEPTH_DEF,
  parameter int CONN_FLUSH_CYC = sclog_pkg::CONN_FLUSH_CYC,
  parameter int FAST_FLUSH_CYC = sclog_pkg::FAST_FLUSH_CYC,
  parameter int ESC_GUARD_CYC = sclog_pkg::ESC_GUARD_CYC,
  parameter int ESC_WINDOW_CYC = sclog_pkg::ESC_WINDOW_CYC,
  parameter int ESC_WAIT_CYC = sclog_pkg::ESC_WAIT_CYC,
  parameter int STAMP_CYC = sclog_pkg::STAMP_CYC
) (
  input logic clk_sys,
  input logic rstn,
  input logic [5:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input sclog_pkg::sclog_byte_type rxRs232,
  input sclog_pkg::sclog_byte_type rxLogic,
  output sclog_pkg::sclog_byte_type txRs232,
  output sclog_pkg::sclog_byte_type txLogic,
  output sclog_pkg::sclog_byte_type cmdByte,
  output logic cmdChan,
  output logic cardValid,
  output sclog_pkg::sclog_rec_type cardData,
  input logic cardReady,
  input logic cardPresent,
  output logic cardFlush,
  output logic cardNewFile,
  output logic cardAppend,
  output logic markupFormat,
  input logic trigFire,
  output logic [9:0] ledBar,
  output logic escMsg,
  output logic escPort
);
  import sclog_pkg::*;

  typedef struct packed {
    sclog_mode_type mode;
    logic logEn;
    logic markup;
    logic trigStop;
    logic [1:0] cmdDis;
    logic portSel;
    logic [1:0][7:0] escChar;
    logic [31:0] limit;
    logic [31:0] lineRate;
    logic escaped;
    logic hsMode;
    logic overflow;
    logic [31:0] fileBytes;
    logic [31:0] flushCnt;
    logic [31:0] msCnt;
    logic [26:0] stampMs;
    logic cardPrev;
    logic [9:0] led;
    sclog_esc_type escSt;
    logic [1:0] escCnt;
    logic escPortR;
    logic [31:0] escTimer;
    logic [31:0] idleCnt;
    logic ack;
    logic [31:0] readData;
    sclog_byte_type txA;
    sclog_byte_type txB;
    sclog_byte_type cmd;
    logic cmdChan;
    logic flush;
    logic newFile;
    logic escMsg;
    logic pend;
    logic [7:0] pendData;
  } sclog_state_type;

  sclog_state_type st_r, st_nxt;
  logic busWr, logging, connLive, cardTake, fifoInReady, fifoOutValid;
  logic pushValid, anyRx, isEsc0, isEsc1;
  sclog_rec_type pushRec, fifoOut;
  sclog_byte_type selRx;
  logic [31:0] flushPeriod, ctrlRd, statRd;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: one wait state, read data latched in the first cycle
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
  assign busWr = avs_write & st_r.ack;
  assign avs_readdata = st_r.readData;
  assign ctrlRd = {24'h000000, st_r.portSel, st_r.cmdDis, st_r.trigStop, st_r.markup, st_r.logEn, st_r.mode};
  assign statRd = {26'h0000000, st_r.mode, st_r.overflow, st_r.hsMode, st_r.escaped, cardPresent};

  // ----------------------------------------------------------------
  // Datapath helpers
  // ----------------------------------------------------------------
  assign connLive = (st_r.mode == MODE_CONNECT) & ~st_r.escaped;
  assign logging = ((st_r.mode == MODE_CONNECT) & st_r.logEn) | (st_r.mode == MODE_PLAIN)
                 | (st_r.mode == MODE_FAST);
  assign flushPeriod = (st_r.mode == MODE_FAST) ? 32'(FAST_FLUSH_CYC - 1) : 32'(CONN_FLUSH_CYC - 1);
  assign selRx = st_r.portSel ? rxLogic : rxRs232;
  assign anyRx = rxRs232.valid | rxLogic.valid;
  assign isEsc0 = rxRs232.valid & (rxRs232.data == st_r.escChar[0]);
  assign isEsc1 = rxLogic.valid & (rxLogic.data == st_r.escChar[1]);
  // Card writer may not take a record in the cycle a new file is opened
  assign cardValid = fifoOutValid & cardPresent & ~st_r.newFile;
  assign cardTake = cardValid & cardReady;
  assign cardData = fifoOut;

  always_comb begin
    pushValid = 1'b0;
    pushRec = '0;
    pushRec.stampMs = st_r.stampMs;
    if (cardPresent && logging) begin
      if (st_r.mode == MODE_CONNECT) begin
        if (st_r.pend) begin
          pushValid = 1'b1;
          pushRec.chan = 1'b1;
          pushRec.data = st_r.pendData;
        end else if (rxRs232.valid || rxLogic.valid) begin
          pushValid = 1'b1;
          pushRec.chan = ~rxRs232.valid;
          pushRec.data = rxRs232.valid ? rxRs232.data : rxLogic.data;
        end
      end else if (selRx.valid) begin
        pushValid = 1'b1;
        pushRec.chan = st_r.portSel;
        pushRec.data = selRx.data;
      end
    end
  end

  sclog_fifo #(.WIDTH($bits(sclog_rec_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inValid(pushValid),
    .inData(pushRec),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOut),
    .outReady(cardTake)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.flush = 1'b0;
    st_nxt.newFile = 1'b0;
    st_nxt.escMsg = 1'b0;
    st_nxt.txA = '0;
    st_nxt.txB = '0;
    st_nxt.cmd = '0;
    st_nxt.cardPrev = cardPresent;
    st_nxt.ack = (avs_read | avs_write) & ~st_r.ack;
    if ((avs_read | avs_write) && !st_r.ack) begin
      case (avs_address)
        ADDR_CTRL: st_nxt.readData = ctrlRd;
        ADDR_STATUS: st_nxt.readData = statRd;
        ADDR_LIMIT: st_nxt.readData = st_r.limit;
        ADDR_ESCCHAR: st_nxt.readData = {16'h0000, st_r.escChar};
        ADDR_RATE: st_nxt.readData = st_r.lineRate;
        ADDR_FILEBYTES: st_nxt.readData = st_r.fileBytes;
        default: st_nxt.readData = 32'h00000000;
      endcase
    end
    // Timestamp in milliseconds
    if (st_r.msCnt == 32'(STAMP_CYC - 1)) begin
      st_nxt.msCnt = 32'h00000000;
      st_nxt.stampMs = st_r.stampMs + 27'h0000001;
    end else begin
      st_nxt.msCnt = st_r.msCnt + 32'h00000001;
    end
    // Configuration is cleared only by rstn; card removal only ends fast mode
    if (busWr) begin
      case (avs_address)
        ADDR_CTRL: begin
          if (avs_byteenable[0]) begin
            st_nxt.mode = sclog_mode_type'(avs_writedata[CTRL_MODE_LSB +: 2]);
            st_nxt.logEn = avs_writedata[CTRL_LOGEN];
            st_nxt.markup = avs_writedata[CTRL_MARKUP];
            st_nxt.trigStop = avs_writedata[CTRL_TRIGSTOP];
            st_nxt.cmdDis = avs_writedata[CTRL_CMDDIS_LSB +: 2];
            st_nxt.portSel = avs_writedata[CTRL_PORTSEL];
            st_nxt.escaped = 1'b0;
            st_nxt.escSt = ESC_IDLE;
            st_nxt.idleCnt = 32'h00000000;
            // Fast start replaces connect; rate decides store-only mode
            st_nxt.hsMode = (avs_writedata[CTRL_MODE_LSB +: 2] == MODE_FAST) && (st_r.lineRate > HS_RATE_BPS);
          end
        end
        ADDR_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[STAT_OVF]) begin
            st_nxt.overflow = 1'b0;
          end
          if (avs_byteenable[0] && avs_writedata[STAT_ESCAPED]) begin
            st_nxt.escaped = 1'b0;
          end
        end
        ADDR_LIMIT: st_nxt.limit = merge(st_r.limit, avs_writedata, avs_byteenable);
        ADDR_ESCCHAR: begin
          if (avs_byteenable[0]) begin
            st_nxt.escChar[0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            st_nxt.escChar[1] = avs_writedata[15:8];
          end
        end
        ADDR_RATE: st_nxt.lineRate = merge(st_r.lineRate, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
    // Fast capture ends on card removal or, in trigger variant, a trigger
    if (st_r.mode == MODE_FAST) begin
      if ((st_r.cardPrev && !cardPresent) || (st_r.trigStop && trigFire)) begin
        st_nxt.mode = MODE_CMD;
        st_nxt.hsMode = 1'b0;
      end
    end
    // Forwarding
    // Idle receive data is not passed on, so an idle output stays all zero
    if (connLive && rxRs232.valid) begin
      st_nxt.txB = rxRs232;
    end
    if (connLive && rxLogic.valid) begin
      st_nxt.txA = rxLogic;
    end
    // Command bytes reach the parser only in command mode or escaped connect
    if ((st_r.mode == MODE_CMD) || ((st_r.mode == MODE_CONNECT) && st_r.escaped)) begin
      if (rxRs232.valid && !st_r.cmdDis[0]) begin
        st_nxt.cmd = rxRs232;
        st_nxt.cmdChan = 1'b0;
      end else if (rxLogic.valid && !st_r.cmdDis[1]) begin
        st_nxt.cmd = rxLogic;
        st_nxt.cmdChan = 1'b1;
      end
    end
    // Record path: second of two simultaneous bytes waits one cycle
    st_nxt.pend = 1'b0;
    if (pushValid && !st_r.pend && rxRs232.valid && rxLogic.valid && (st_r.mode == MODE_CONNECT)) begin
      st_nxt.pend = 1'b1;
      st_nxt.pendData = rxLogic.data;
    end
    if ((pushValid && !fifoInReady) || (st_r.pend && anyRx && logging)) begin
      st_nxt.overflow = 1'b1;
    end
    // File accounting
    if (cardTake) begin
      if (st_r.fileBytes == st_r.limit - 32'h00000001) begin
        st_nxt.newFile = 1'b1;
        st_nxt.fileBytes = 32'h00000000;
      end else begin
        st_nxt.fileBytes = st_r.fileBytes + 32'h00000001;
      end
    end
    if (cardPresent && !st_r.cardPrev && logging) begin
      st_nxt.newFile = 1'b1;
      st_nxt.fileBytes = 32'h00000000;
    end
    // Periodic flush
    if (!logging) begin
      st_nxt.flushCnt = 32'h00000000;
    end else if (st_r.flushCnt >= flushPeriod) begin
      st_nxt.flushCnt = 32'h00000000;
      st_nxt.flush = 1'b1;
    end else begin
      st_nxt.flushCnt = st_r.flushCnt + 32'h00000001;
    end
    // Escape detection on either port, each with its own character
    if (connLive) begin
      case (st_r.escSt)
        ESC_IDLE: begin
          if (anyRx) begin
            st_nxt.idleCnt = 32'h00000000;
          end else if (st_r.idleCnt >= 32'(ESC_GUARD_CYC - 1)) begin
            st_nxt.escSt = ESC_ARMED;
          end else begin
            st_nxt.idleCnt = st_r.idleCnt + 32'h00000001;
          end
        end
        ESC_ARMED: begin
          if (isEsc0 ^ isEsc1) begin
            st_nxt.escSt = ESC_COUNT;
            st_nxt.escCnt = 2'h1;
            st_nxt.escPortR = isEsc1;
            st_nxt.escTimer = 32'h00000000;
          end else if (anyRx) begin
            st_nxt.escSt = ESC_IDLE;
            st_nxt.idleCnt = 32'h00000000;
          end
        end
        ESC_COUNT: begin
          st_nxt.escTimer = st_r.escTimer + 32'h00000001;
          if ((st_r.escPortR ? (isEsc1 && !rxRs232.valid) : (isEsc0 && !rxLogic.valid))) begin
            st_nxt.escCnt = st_r.escCnt + 2'h1;
            if (st_r.escCnt == 2'h2) begin
              st_nxt.escSt = ESC_WAIT;
              st_nxt.escTimer = 32'h00000000;
            end
          end else if (anyRx || (st_r.escTimer >= 32'(ESC_WINDOW_CYC - 1))) begin
            st_nxt.escSt = ESC_IDLE;
            st_nxt.idleCnt = 32'h00000000;
          end
        end
        ESC_WAIT: begin
          if (anyRx) begin
            st_nxt.escSt = ESC_IDLE;
            st_nxt.idleCnt = 32'h00000000;
          end else if (st_r.escTimer >= 32'(ESC_WAIT_CYC - 1)) begin
            st_nxt.escaped = 1'b1;
            st_nxt.escMsg = 1'b1;
            st_nxt.escSt = ESC_IDLE;
            st_nxt.idleCnt = 32'h00000000;
          end else begin
            st_nxt.escTimer = st_r.escTimer + 32'h00000001;
          end
        end
        default: st_nxt.escSt = ESC_IDLE;
      endcase
    end
    // Indicators; frozen entirely while in store-only mode
    if (!st_r.hsMode) begin
      if (st_r.mode == MODE_CONNECT) begin
        st_nxt.led[LED_CONN_OFF_A] = 1'b0;
        st_nxt.led[LED_CONN_OFF_B] = 1'b0;
        st_nxt.led[LED_RS232] = st_r.led[LED_RS232] ^ rxRs232.valid;
        st_nxt.led[LED_LOGIC] = st_r.led[LED_LOGIC] ^ rxLogic.valid;
      end else if (st_r.mode == MODE_FAST) begin
        st_nxt.led[LED_FAST] = st_r.led[LED_FAST] ^ cardTake;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.limit <= LIMIT_RST;
      st_r.lineRate <= RATE_RST;
      st_r.escChar <= {ESC_LOGIC_RST, ESC_RS232_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txRs232 = st_r.txA;
  assign txLogic = st_r.txB;
  assign cmdByte = st_r.cmd;
  assign cmdChan = st_r.cmdChan;
  assign cardFlush = st_r.flush;
  assign cardNewFile = st_r.newFile;
  assign cardAppend = st_r.mode == MODE_FAST;
  assign markupFormat = st_r.markup;
  assign ledBar = st_r.led;
  assign escMsg = st_r.escMsg;
  assign escPort = st_r.escPortR;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_fwd;
    connLive && rxRs232.valid |=> txLogic.valid && txLogic.data == $past(rxRs232.data);
  endproperty
  a_fwd: assert property (p_fwd) else $error("byte not forwarded to logic port");
  property p_connFlush;
    (st_r.mode == MODE_CONNECT) && logging && st_r.flushCnt == 32'(CONN_FLUSH_CYC - 1) |=> cardFlush;
  endproperty
  a_connFlush: assert property (p_connFlush) else $error("connect flush missed");
  property p_fastFlush;
    (st_r.mode == MODE_FAST) && st_r.flushCnt == 32'(FAST_FLUSH_CYC - 1) |=> cardFlush ##1 !cardFlush;
  endproperty
  a_fastFlush: assert property (p_fastFlush) else $error("fast flush missed");
  property p_reinsert;
    logging && cardPresent && !st_r.cardPrev |=> cardNewFile && st_r.fileBytes == 32'h00000000;
  endproperty
  a_reinsert: assert property (p_reinsert) else $error("no new file on reinsertion");
  property p_removal;
    (st_r.mode == MODE_FAST) && st_r.cardPrev && !cardPresent |=> st_r.mode == MODE_CMD && !st_r.hsMode;
  endproperty
  a_removal: assert property (p_removal) else $error("fast capture kept after removal");
  property p_trig;
    (st_r.mode == MODE_FAST) && st_r.trigStop && trigFire |=> st_r.mode == MODE_CMD;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not end capture");
  property p_freeze;
    st_r.hsMode |=> ledBar == $past(ledBar);
  endproperty
  a_freeze: assert property (p_freeze) else $error("LEDs moved in store-only mode");
  sequence s_lastByte;
    cardTake && st_r.fileBytes == st_r.limit - 32'h00000001;
  endsequence
  property p_roll;
    s_lastByte |=> cardNewFile && st_r.fileBytes == 32'h00000000 && !cardValid;
  endproperty
  a_roll: assert property (p_roll) else $error("file not rolled at limit");
  property p_fastLed;
    (st_r.mode == MODE_FAST) && !st_r.hsMode && cardTake |=> ledBar[LED_FAST] != $past(ledBar[LED_FAST]);
  endproperty
  a_fastLed: assert property (p_fastLed) else $error("write LED did not toggle");
  property p_cmdDis;
    st_r.cmdDis[0] && rxRs232.valid && !rxLogic.valid |=> !cmdByte.valid;
  endproperty
  a_cmdDis: assert property (p_cmdDis) else $error("disabled port reached parser");
  property p_connLed;
    (st_r.mode == MODE_CONNECT) && !st_r.hsMode && rxRs232.valid |=> ledBar[LED_RS232] != $past(ledBar[LED_RS232])
      && !ledBar[LED_CONN_OFF_A] && !ledBar[LED_CONN_OFF_B];
  endproperty
  a_connLed: assert property (p_connLed) else $error("connect LED wrong");
endmodule // sclog_top

// >>> verif/sclog_line_model.sv
// Serial equipment model driving both receive ports
`timescale 1ns/1ns
module sclog_line_model (
  input logic clk_sys,
  input logic sendGo,
  input logic sendChan,
  input logic [7:0] sendData,
  output sclog_pkg::sclog_byte_type rxRs232,
  output sclog_pkg::sclog_byte_type rxLogic
);
  import sclog_pkg::*;
  initial begin
    rxRs232 = '0;
    rxLogic = '0;
  end
  // Idle data flips every cycle so nothing can lean on a stale byte
  always @(posedge clk_sys) begin
    rxRs232.valid <= sendGo & ~sendChan;
    rxRs232.data <= (sendGo & ~sendChan) ? sendData : ~rxRs232.data;
    rxLogic.valid <= sendGo & sendChan;
    rxLogic.data <= (sendGo & sendChan) ? sendData : ~rxLogic.data;
  end
endmodule // sclog_line_model

// >>> verif/tb_sclog_top.sv
// Self-checking testbench of the serial capture logger
`timescale 1ns/1ns
module tb_sclog_top;
  import sclog_pkg::*;
  logic clk_sys = 0, rstn = 0, avs_read = 0, avs_write = 0, cardReady = 0, cardPresent = 1, trigFire = 0;
  logic sendGo = 0, sendChan = 0, avs_waitrequest, cardValid, cardFlush, cardNewFile, cardAppend;
  logic markupFormat, escMsg, escPort, cmdChan;
  logic [5:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic [7:0] sendData = '0;
  logic [9:0] ledBar;
  sclog_byte_type rxRs232, rxLogic, txRs232, txLogic, cmdByte;
  sclog_rec_type cardData;
  int failures = 0, n_compared = 0, i;
  // Row: port, byte, expected logic-side output, expected rs232-side output
  logic [26:0] rows [4] = '{{1'b0, 8'h41, 9'h141, 9'h000}, {1'b1, 8'ha5, 9'h000, 9'h1a5},
    {1'b0, 8'h00, 9'h100, 9'h000}, {1'b1, 8'hff, 9'h000, 9'h1ff}};

  // Window and stamp periods keep their defaults: no scenario runs long enough to reach them
  sclog_top #(.FIFO_DEPTH(4), .CONN_FLUSH_CYC(40), .FAST_FLUSH_CYC(20), .ESC_GUARD_CYC(30),
    .ESC_WAIT_CYC(40)) sclog_top_inst (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rxRs232(rxRs232), .rxLogic(rxLogic), .txRs232(txRs232), .txLogic(txLogic), .cmdByte(cmdByte),
    .cmdChan(cmdChan), .cardValid(cardValid), .cardData(cardData), .cardReady(cardReady),
    .cardPresent(cardPresent), .cardFlush(cardFlush), .cardNewFile(cardNewFile), .cardAppend(cardAppend),
    .markupFormat(markupFormat), .trigFire(trigFire), .ledBar(ledBar), .escMsg(escMsg), .escPort(escPort));
  sclog_line_model sclog_line_model_inst (.clk_sys(clk_sys), .sendGo(sendGo), .sendChan(sendChan),
    .sendData(sendData), .rxRs232(rxRs232), .rxLogic(rxLogic));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task final_report;
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until the edge that samples waitrequest low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(negedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      final_report;
    end
  endtask

  // One byte from the far side, spaced three cycles apart, one beyond the two-cycle minimum
  task send(input logic c, input logic [7:0] d);
    @(posedge clk_sys);
    sendGo <= 1'b1;
    sendChan <= c;
    sendData <= d;
    @(posedge clk_sys);
    sendGo <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task waitsig(input logic [1:0] sel, input int lim);
    logic hit;
    hit = 0;
    for (int n = 0; n < lim && !hit; n++) begin
      @(negedge clk_sys);
      hit = (sel == 2'h2) ? (cardNewFile === 1'b1) : sel[0] ? (cardFlush === 1'b1) : (escMsg === 1'b1);
    end
    chk(32'(hit), 32'h1);
    if (!hit) final_report;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    bus(1'b0, ADDR_LIMIT, 32'h0);
    chk(q, 32'hee6b2800);
    bus(1'b0, ADDR_ESCCHAR, 32'h0);
    chk(q, 32'h0000262d);
    bus(1'b0, 6'h3c, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h00000005);
    for (i = 0; i < 4; i++) begin
      send(rows[i][26], rows[i][25:18]);
      chk(32'(txLogic), 32'(rows[i][17:9]));
      chk(32'(txRs232), 32'(rows[i][8:0]));
      chk(32'(cardValid), 32'h1);
    end
    chk(32'({cardData.chan, cardData.data}), 32'h41);
    repeat (35) @(posedge clk_sys);
    repeat (3) send(1'b0, 8'h2d);
    waitsig(2'h0, 100);
    chk(32'(escPort), 32'h0);
    send(1'b1, 8'h41);
    chk(32'({cmdChan, cmdByte}), 32'h341);
    chk(32'(ledBar), 32'h180);
    bus(1'b1, ADDR_CTRL, 32'h00000003);
    @(negedge clk_sys);
    chk(32'(cardAppend), 32'h1);
    waitsig(2'h1, 25);
    @(posedge clk_sys);
    cardPresent <= 1'b0;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(q[5:4]), 32'h0);
    chk(32'(cardAppend), 32'h0);
    // Store-only capture with a two-byte file limit, then a trigger ends it
    bus(1'b1, ADDR_LIMIT, 32'h00000002);
    avs_byteenable <= 4'h4;
    bus(1'b1, ADDR_RATE, 32'h00200000);
    avs_byteenable <= 4'hf;
    cardPresent <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h00000013);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(32'({q[5:4], q[2]}), 32'h7);
    cardReady <= 1'b1;
    waitsig(2'h2, 10);
    @(posedge clk_sys);
    trigFire <= 1'b1;
    @(posedge clk_sys);
    trigFire <= 1'b0;
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(32'({q[5:4], q[2]}), 32'h0);
    // Plain logging with markup; a card swap must open a new file
    bus(1'b1, ADDR_CTRL, 32'h0000000a);
    cardPresent <= 1'b0;
    @(posedge clk_sys);
    cardPresent <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(cardNewFile), 32'h1);
    chk(32'(markupFormat), 32'h1);
    final_report;
  end
endmodule // tb_sclog_top
